/* File: hw/sdc_defines.svh */
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// descriptor layout, bit positions within the 64-bit descriptor
`define SDC_LIM_LO_MSB 15
`define SDC_BASE_LO_LSB 16
`define SDC_BASE_MID_MSB 39
`define SDC_AR_LSB 40
`define SDC_AR_P 47
`define SDC_AR_DPL_MSB 46
`define SDC_AR_DPL_LSB 45
`define SDC_AR_S 44
`define SDC_AR_E 43
`define SDC_AR_B2 42
`define SDC_AR_B1 41
`define SDC_AR_A 40
`define SDC_LIM_HI_LSB 48
`define SDC_LIM_HI_MSB 51
`define SDC_DFLAG 54
`define SDC_GRAN 55
`define SDC_BASE_HI_LSB 56
`define SDC_LEGACY_LSB 48

// limit scaling and stack bounds
`define SDC_PAGE_FILL 12'hfff
`define SDC_TOP_BIG 32'h0fff_ffff
`define SDC_TOP_SMALL 32'h0000_ffff

// exception numbers
`define SDC_VEC_NONE 8'h00
`define SDC_VEC_NP 8'h0b
`define SDC_VEC_GP 8'h0d

// register map
`define SDC_REG_CTRL 8'h00
`define SDC_REG_STAT 8'h04
`define SDC_REG_INT_STAT 8'h08
`define SDC_REG_INT_MASK 8'h0c
`define SDC_REG_LAST_ADDR 8'h10
`define SDC_REG_FAULT_CNT 8'h14

// control fields
`define SDC_CTRL_CHECK 0
`define SDC_CTRL_ABIT 1
`define SDC_CTRL_RST 2'h3

// interrupt status fields
`define SDC_INT_NP 0
`define SDC_INT_GP 1
`define SDC_INT_ACC 2

`endif

/* File: hw/sdc_pkg.sv */
package sdc_pkg;

    typedef enum logic [1:0] {
        SDC_ACC_READ,
        SDC_ACC_WRITE,
        SDC_ACC_EXEC,
        SDC_ACC_LOAD
    } sdc_acc_type;

endpackage

/* File: hw/sdc_dec_if.sv */
`timescale 1ns/1ns
interface sdc_dec_if;
    logic [63:0] desc;
    logic present;
    logic [1:0] descriptor_priv_level;
    logic is_seg;
    logic is_code;
    logic bit2;
    logic bit1;
    logic accessed;
    logic dflag;
    logic legacy;
    logic [31:0] base;
    logic [31:0] limit;

    modport dec (input desc, output present, descriptor_priv_level, is_seg, is_code, bit2, bit1,
        accessed, dflag, legacy, base, limit);
    modport host (output desc, input present, descriptor_priv_level, is_seg, is_code, bit2, bit1,
        accessed, dflag, legacy, base, limit);
endinterface

/* File: hw/sdc_field_decode.sv */
`timescale 1ns/1ns
`include "sdc_defines.svh"
module sdc_field_decode (
    sdc_dec_if.dec d
);
    logic [19:0] lim20;

    // granular segments fill the low twelve bits so the last page is whole
    function automatic logic [31:0] sdc_scale(input logic [19:0] lim, input logic gran);
        sdc_scale = gran ? {lim, `SDC_PAGE_FILL} : {12'h000, lim};
    endfunction

    assign lim20 = {d.desc[`SDC_LIM_HI_MSB:`SDC_LIM_HI_LSB], d.desc[`SDC_LIM_LO_MSB:0]};
    assign d.present = d.desc[`SDC_AR_P]; // RULE_01
    assign d.descriptor_priv_level = d.desc[`SDC_AR_DPL_MSB:`SDC_AR_DPL_LSB]; // RULE_03
    assign d.is_seg = d.desc[`SDC_AR_S]; // RULE_04
    assign d.is_code = d.desc[`SDC_AR_E]; // RULE_05
    assign d.bit2 = d.desc[`SDC_AR_B2];
    assign d.bit1 = d.desc[`SDC_AR_B1];
    assign d.accessed = d.desc[`SDC_AR_A];
    assign d.dflag = d.desc[`SDC_DFLAG];
    // legacy format only applies to system descriptors
    assign d.legacy = !d.desc[`SDC_AR_S] && (d.desc[63:`SDC_LEGACY_LSB] == 16'h0000); // RULE_16

    always_comb begin
        if (d.legacy) begin
            d.base = {8'h00, d.desc[`SDC_BASE_MID_MSB:`SDC_BASE_LO_LSB]}; // RULE_16
            d.limit = {16'h0000, d.desc[`SDC_LIM_LO_MSB:0]}; // RULE_16
        end else begin
            d.base = {d.desc[63:`SDC_BASE_HI_LSB],
                d.desc[`SDC_BASE_MID_MSB:`SDC_BASE_LO_LSB]}; // RULE_15
            d.limit = sdc_scale(lim20, d.desc[`SDC_GRAN]); // RULE_12 RULE_15
        end
    end
endmodule // sdc_field_decode

/* File: hw/sdc_checker.sv */
`timescale 1ns/1ns
`include "sdc_defines.svh"
// Function
// (RULE_01) access-rights bit 7 is presence; absent segment ignores base and limit; the code still loads base plus offset into last_addr_r
// (RULE_02) access to an absent segment raises not-present fault, exception 11
// (RULE_03) bits 6..5 are descriptor privilege level used in privilege comparisons
// (RULE_04) bit 4 set means code or data, clear means system or gate
// (RULE_05) bit 3 selects data segment (0) or code segment (1)
// (RULE_06) data bit 2: expand up needs offset <= limit, down needs > limit
// (RULE_07) data bit 1 clear refuses writes, set permits them
// (RULE_08) conforming code executes only when current level >= descriptor level
// (RULE_09) code bit 1 clear is execute-only, reads refused; set allows reads
// (RULE_10) every write through a code descriptor is refused
// (RULE_11) accessed bit 0 is set whenever the descriptor is accessed or loaded
// (RULE_12) 20-bit limit scales by bytes or 4 Kbyte pages per granularity
// (RULE_13) code default-size flag picks 32-bit or 16-bit operands and addressing
// (RULE_14) stack big flag picks 32-bit pointer bound or 16-bit bound ffffh; the code uses 0fffffffh as the big bound
// (RULE_15) current-format descriptors give 32-bit base and 20-bit limit
// (RULE_16) upper 16 bits zero marks legacy system descriptor: 24-bit base, 16-bit limit
// (RULE_17) limit or permission violation signals protection fault, suppresses access
// (RULE_18) loader presents full descriptor, access type and level before a check
module sdc_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic [63:0] req_desc,
    input wire sdc_pkg::sdc_acc_type req_acc,
    input wire logic [1:0] req_cpl,
    input wire logic [31:0] req_offset,
    input wire logic req_stack,
    output logic resp_valid,
    output logic resp_fault,
    output logic [7:0] resp_vector,
    output logic resp_mem_en,
    output logic [31:0] resp_lin_addr,
    output logic resp_op32,
    output logic resp_stack32,
    output logic [31:0] resp_stack_top,
    output logic [63:0] resp_desc,
    output logic resp_desc_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    sdc_dec_if dif();

    logic [1:0] ctrl_r;
    logic [2:0] int_stat_r;
    logic [2:0] int_stat_nxt;
    logic [2:0] int_mask_r;
    logic [7:0] last_vec_r;
    logic last_fault_r;
    logic [31:0] last_addr_r;
    logic [31:0] fault_cnt_r;

    logic check_en;
    logic abit_en;
    logic is_read;
    logic is_write;
    logic is_exec;
    logic is_load;
    logic [31:0] top;
    logic lim_bad;
    logic perm_bad;
    logic priv_bad;
    logic np_fault;
    logic gp_fault;
    logic set_acc;
    logic [7:0] vec;
    logic [2:0] events;

    // the loader must hold all request fields valid with req_valid
    assign dif.desc = req_desc; // RULE_18

    sdc_field_decode u_dec (
        .d(dif)
    );

    assign check_en = ctrl_r[`SDC_CTRL_CHECK];
    assign abit_en = ctrl_r[`SDC_CTRL_ABIT];
    assign is_read = (req_acc == sdc_pkg::SDC_ACC_READ);
    assign is_write = (req_acc == sdc_pkg::SDC_ACC_WRITE);
    assign is_exec = (req_acc == sdc_pkg::SDC_ACC_EXEC);
    assign is_load = (req_acc == sdc_pkg::SDC_ACC_LOAD);

    // stack bound follows the big flag of a data segment
    assign top = dif.dflag ? `SDC_TOP_BIG : `SDC_TOP_SMALL; // RULE_14

    // limit check; selector loads touch no memory and skip it
    always_comb begin
        lim_bad = 1'b0;
        if (!is_load) begin
            if (dif.is_seg && !dif.is_code && dif.bit2) begin
                lim_bad = (req_offset <= dif.limit) || (req_offset > top); // RULE_06 RULE_14
            end else begin
                lim_bad = (req_offset > dif.limit); // RULE_06 RULE_12
            end
        end
    end

    // type permissions
    always_comb begin
        perm_bad = 1'b0;
        if (!dif.is_seg) begin
            // system descriptors only back selector loads here
            perm_bad = !is_load; // RULE_04
        end else if (dif.is_code) begin
            if (is_write) begin
                perm_bad = 1'b1; // RULE_10
            end else if (is_read) begin
                perm_bad = !dif.bit1; // RULE_09
            end
        end else begin
            if (is_write) begin
                perm_bad = !dif.bit1; // RULE_07
            end else if (is_exec) begin
                perm_bad = 1'b1; // RULE_05
            end
        end
    end

    // privilege comparisons against the descriptor level
    always_comb begin
        priv_bad = 1'b0;
        if (dif.is_seg && dif.is_code && dif.bit2 && is_exec) begin
            priv_bad = (req_cpl < dif.descriptor_priv_level); // RULE_08
        end else if (dif.is_seg && !dif.is_code && !is_exec) begin
            priv_bad = (req_cpl > dif.descriptor_priv_level); // RULE_03
        end
    end

    // an absent segment is refused before any limit or type test
    assign np_fault = !dif.present; // RULE_01 RULE_02
    assign gp_fault = dif.present && check_en && (lim_bad || perm_bad || priv_bad); // RULE_17
    // the accessed bit only exists for code and data descriptors
    assign set_acc = dif.present && dif.is_seg && !dif.accessed && abit_en; // RULE_11

    always_comb begin
        if (np_fault) begin
            vec = `SDC_VEC_NP; // RULE_02
        end else if (gp_fault) begin
            vec = `SDC_VEC_GP; // RULE_17
        end else begin
            vec = `SDC_VEC_NONE;
        end
    end

    // answer, registered one cycle after the request
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resp_valid <= 1'b0;
            resp_fault <= 1'b0;
            resp_vector <= `SDC_VEC_NONE;
            resp_mem_en <= 1'b0;
        end else begin
            resp_valid <= req_valid;
            resp_fault <= req_valid && (np_fault || gp_fault); // RULE_02 RULE_17
            resp_vector <= req_valid ? vec : `SDC_VEC_NONE;
            // faulting accesses never reach memory
            resp_mem_en <= req_valid && !is_load && !np_fault && !gp_fault; // RULE_17
        end
    end

    // address and size attributes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resp_lin_addr <= 32'h0000_0000;
            resp_op32 <= 1'b0;
            resp_stack32 <= 1'b0;
            resp_stack_top <= `SDC_TOP_SMALL;
        end else if (req_valid) begin
            // base is meaningless for an absent segment
            resp_lin_addr <= dif.present ? dif.base + req_offset : 32'h0000_0000; // RULE_01
            resp_op32 <= dif.is_seg && dif.is_code && dif.dflag; // RULE_13
            resp_stack32 <= dif.is_seg && !dif.is_code && dif.dflag && req_stack; // RULE_14
            resp_stack_top <= top; // RULE_14
        end
    end

    // accessed flag write-back
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resp_desc <= 64'h0000_0000_0000_0000;
            resp_desc_wr <= 1'b0;
        end else begin
            resp_desc_wr <= req_valid && set_acc; // RULE_11
            if (req_valid) begin
                resp_desc <= req_desc;
                resp_desc[`SDC_AR_A] <= req_desc[`SDC_AR_A] || set_acc; // RULE_11
            end
        end
    end

    // control register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `SDC_CTRL_RST;
        end else if (reg_wr && reg_addr == `SDC_REG_CTRL) begin
            ctrl_r <= reg_wdata[1:0];
        end
    end

    assign events[`SDC_INT_NP] = req_valid && np_fault;
    assign events[`SDC_INT_GP] = req_valid && gp_fault;
    assign events[`SDC_INT_ACC] = req_valid && set_acc;

    // write one to clear; a new event in the same cycle wins
    always_comb begin
        int_stat_nxt = int_stat_r;
        if (reg_wr && reg_addr == `SDC_REG_INT_STAT) begin
            int_stat_nxt = int_stat_r & ~reg_wdata[2:0];
        end
        int_stat_nxt = int_stat_nxt | events;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            int_stat_r <= 3'h0;
        end else begin
            int_stat_r <= int_stat_nxt;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            int_mask_r <= 3'h0;
        end else if (reg_wr && reg_addr == `SDC_REG_INT_MASK) begin
            int_mask_r <= reg_wdata[2:0];
        end
    end

    // taken from the next status so irq is a flop yet tracks status exactly
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_nxt & int_mask_r);
        end
    end

    // last outcome and fault count for software
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            last_vec_r <= `SDC_VEC_NONE;
            last_fault_r <= 1'b0;
            last_addr_r <= 32'h0000_0000;
        end else if (req_valid) begin
            last_vec_r <= vec;
            last_fault_r <= np_fault || gp_fault;
            last_addr_r <= dif.base + req_offset;
        end
    end

    // counter saturates rather than wrap so a flood stays visible
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fault_cnt_r <= 32'h0000_0000;
        end else if (reg_wr && reg_addr == `SDC_REG_FAULT_CNT) begin
            fault_cnt_r <= 32'h0000_0000;
        end else if (req_valid && (np_fault || gp_fault) && fault_cnt_r != 32'hffff_ffff) begin
            fault_cnt_r <= fault_cnt_r + 32'h0000_0001;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SDC_REG_CTRL: begin
                    reg_rdata <= {30'h0, ctrl_r};
                end
                `SDC_REG_STAT: begin
                    reg_rdata <= {23'h0, last_fault_r, last_vec_r};
                end
                `SDC_REG_INT_STAT: begin
                    reg_rdata <= {29'h0, int_stat_r};
                end
                `SDC_REG_INT_MASK: begin
                    reg_rdata <= {29'h0, int_mask_r};
                end
                `SDC_REG_LAST_ADDR: begin
                    reg_rdata <= last_addr_r;
                end
                `SDC_REG_FAULT_CNT: begin
                    reg_rdata <= fault_cnt_r;
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // sdc_checker

/* File: testbench/sdc_checker_properties.sv */
`timescale 1ns/1ns
module sdc_checker_properties (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic [63:0] req_desc,
    input wire sdc_pkg::sdc_acc_type req_acc,
    input wire logic [1:0] req_cpl,
    input wire logic [31:0] req_offset,
    input wire logic req_stack,
    input wire logic resp_valid,
    input wire logic resp_fault,
    input wire logic [7:0] resp_vector,
    input wire logic resp_mem_en,
    input wire logic [31:0] resp_lin_addr,
    input wire logic resp_op32,
    input wire logic [31:0] resp_stack_top,
    input wire logic [63:0] resp_desc
);
    logic seg, cd, dt, lok;
    assign seg = req_valid & req_desc[47] & req_desc[44];
    assign cd = seg & req_desc[43];
    assign dt = seg & ~req_desc[43];
    // byte granular only, so page limits cannot mask a level fault
    assign lok = ~req_desc[55] & (req_offset <= {12'h000, req_desc[51:48], req_desc[15:0]});
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    resp_pulse_a: assert property (resp_valid == $past(req_valid))
        else $error("response not one cycle after request");
    absent_fault_a: assert property (req_valid && !req_desc[47] |=>
        resp_fault && resp_vector == 8'h0b && resp_lin_addr == 32'h0)
        else $error("absent segment not faulted");
    fault_nomem_a: assert property (resp_fault |-> !resp_mem_en)
        else $error("memory enabled on fault");
    code_write_a: assert property (cd && req_acc == sdc_pkg::SDC_ACC_WRITE |=> resp_fault)
        else $error("code write allowed");
    ro_write_a: assert property (dt && !req_desc[41] && req_acc == sdc_pkg::SDC_ACC_WRITE
        |=> resp_vector == 8'h0d) else $error("read-only write allowed");
    exec_only_a: assert property (cd && !req_desc[41] && req_acc == sdc_pkg::SDC_ACC_READ
        |=> resp_fault) else $error("execute-only read allowed");
    conf_level_a: assert property (cd && req_desc[42] && lok && req_acc == sdc_pkg::SDC_ACC_EXEC
        |=> resp_fault == ($past(req_cpl) < $past(req_desc[46:45])))
        else $error("conforming level check wrong");
    sys_refuse_a: assert property (req_valid && req_desc[47] && !req_desc[44]
        && req_acc != sdc_pkg::SDC_ACC_LOAD |=> resp_fault) else $error("system access allowed");
    op_size_a: assert property (cd |=> resp_op32 == $past(req_desc[54]))
        else $error("operand size wrong");
    stack_top_a: assert property (dt && req_stack |=> resp_stack_top ==
        ($past(req_desc[54]) ? 32'h0fff_ffff : 32'h0000_ffff)) else $error("stack bound wrong");
    acc_mark_a: assert property (seg |=> resp_desc[40])
        else $error("accessed flag not set");
    legacy_base_a: assert property (req_valid && !req_desc[44] && req_desc[63:48] == 16'h0
        && req_desc[47] |=> resp_lin_addr == {8'h00, $past(req_desc[39:16])} + $past(req_offset))
        else $error("legacy base wrong");
    cover property (req_valid && !req_desc[47]);
    cover property (cd && req_desc[42]);
    cover property (dt && req_desc[42]);
endmodule // sdc_checker_properties

bind sdc_checker sdc_checker_properties props (.mclk, .reset_n, .req_valid, .req_desc,
    .req_acc, .req_cpl, .req_offset, .req_stack, .resp_valid, .resp_fault, .resp_vector,
    .resp_mem_en, .resp_lin_addr, .resp_op32, .resp_stack_top, .resp_desc);

/* File: testbench/sdc_loader.sv */
`timescale 1ns/1ns
module sdc_loader (
    input wire logic mclk,
    output logic req_valid = 1'b0,
    output logic [63:0] req_desc = 64'h0,
    output sdc_pkg::sdc_acc_type req_acc = sdc_pkg::SDC_ACC_READ,
    output logic [1:0] req_cpl = 2'h0,
    output logic [31:0] req_offset = 32'h0,
    output logic req_stack = 1'b0
);
    task automatic issue(input logic [63:0] d, input sdc_pkg::sdc_acc_type a,
        input logic [1:0] c, input logic [31:0] o);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_desc <= d;
        req_acc <= a;
        req_cpl <= c;
        req_offset <= o;
        req_stack <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        // stale descriptor and offset are scrambled so the checker cannot lean on them
        req_desc <= ~d;
        req_offset <= ~o;
        #1;
    endtask
endmodule // sdc_loader

/* File: testbench/sdc_checker_test.sv */
`timescale 1ns/1ns
module sdc_checker_test;
    localparam sdc_pkg::sdc_acc_type RD = sdc_pkg::SDC_ACC_READ;
    localparam sdc_pkg::sdc_acc_type WR = sdc_pkg::SDC_ACC_WRITE;
    localparam sdc_pkg::sdc_acc_type EX = sdc_pkg::SDC_ACC_EXEC;
    localparam sdc_pkg::sdc_acc_type LD = sdc_pkg::SDC_ACC_LOAD;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid, req_stack, irq;
    logic [63:0] req_desc, resp_desc;
    sdc_pkg::sdc_acc_type req_acc;
    logic [1:0] req_cpl;
    logic [31:0] req_offset, resp_lin_addr, resp_stack_top, reg_rdata;
    logic resp_valid, resp_fault, resp_mem_en, resp_op32, resp_stack32, resp_desc_wr;
    logic [7:0] resp_vector;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    int error_cnt = 0;
    int checked = 0;
    always #5 mclk = ~mclk;
    sdc_loader ld (.mclk, .req_valid, .req_desc, .req_acc, .req_cpl, .req_offset, .req_stack);
    sdc_checker dut (.mclk, .reset_n, .req_valid, .req_desc, .req_acc, .req_cpl, .req_offset,
        .req_stack, .resp_valid, .resp_fault, .resp_vector, .resp_mem_en, .resp_lin_addr,
        .resp_op32, .resp_stack32, .resp_stack_top, .resp_desc, .resp_desc_wr, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // base 12345000h, limit 100h; gd carries granularity and size flags
    function automatic logic [63:0] mk(input logic [7:0] ar, input logic [1:0] gd);
        return {8'h12, gd, 6'h00, ar, 24'h34_5000, 16'h0100};
    endfunction
    task automatic chk(input logic [63:0] d, input sdc_pkg::sdc_acc_type a,
        input logic [1:0] c, input logic [31:0] o, input logic f);
        ld.issue(d, a, c, o);
        cmp(resp_valid, 1'b1);
        cmp(resp_fault, f);
        cmp(resp_vector, !f ? 8'h00 : d[47] ? 8'h0d : 8'h0b);
        cmp(resp_mem_en, !f && a != LD);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, e);
    endtask
    task automatic t_limit();
        chk(mk(8'h72, 2'h0), RD, 2'h0, 32'hffff_ffff, 1'b1);
        cmp(resp_lin_addr, 32'h0);
        chk(mk(8'hf2, 2'h0), RD, 2'h0, 32'h100, 1'b0);
        cmp(resp_lin_addr, 32'h1234_5100);
        chk(mk(8'hf2, 2'h0), RD, 2'h0, 32'h101, 1'b1);
        chk(mk(8'hf2, 2'h2), RD, 2'h0, 32'h10_0fff, 1'b0);
        chk(mk(8'hf2, 2'h2), RD, 2'h0, 32'h10_1000, 1'b1);
        chk(mk(8'hf6, 2'h1), WR, 2'h0, 32'h100, 1'b1);
        chk(mk(8'hf6, 2'h1), WR, 2'h0, 32'h101, 1'b0);
        cmp(resp_stack_top, 32'h0fff_ffff);
        cmp(resp_stack32, 1'b1);
        chk(mk(8'hf6, 2'h0), WR, 2'h0, 32'h1_0000, 1'b1);
        cmp(resp_stack_top, 32'h0000_ffff);
        $display("t_limit done");
    endtask
    task automatic t_perm();
        chk(mk(8'hf0, 2'h0), WR, 2'h0, 32'h0, 1'b1);
        chk(mk(8'hf2, 2'h0), WR, 2'h0, 32'h0, 1'b0);
        chk(mk(8'h92, 2'h0), RD, 2'h3, 32'h0, 1'b1);
        chk(mk(8'hf2, 2'h0), EX, 2'h0, 32'h0, 1'b1);
        chk(mk(8'h9a, 2'h0), WR, 2'h0, 32'h0, 1'b1);
        chk(mk(8'h98, 2'h0), RD, 2'h0, 32'h0, 1'b1);
        chk(mk(8'h9a, 2'h0), RD, 2'h0, 32'h0, 1'b0);
        chk(mk(8'h98, 2'h1), EX, 2'h0, 32'h0, 1'b0);
        cmp(resp_op32, 1'b1);
        chk(mk(8'h98, 2'h0), EX, 2'h0, 32'h0, 1'b0);
        cmp(resp_op32, 1'b0);
        chk(mk(8'hdc, 2'h0), EX, 2'h1, 32'h0, 1'b1);
        chk(mk(8'hdc, 2'h0), EX, 2'h2, 32'h0, 1'b0);
        chk(mk(8'hdc, 2'h0), EX, 2'h3, 32'h0, 1'b0);
        $display("t_perm done");
    endtask
    task automatic t_desc();
        chk(mk(8'hf2, 2'h0), LD, 2'h0, 32'h0, 1'b0);
        cmp(resp_desc_wr, 1'b1);
        cmp(resp_desc, mk(8'hf3, 2'h0));
        chk(mk(8'hf3, 2'h0), LD, 2'h0, 32'h0, 1'b0);
        cmp(resp_desc_wr, 1'b0);
        chk({16'h0, 8'h82, 24'hab_cdef, 16'h0010}, LD, 2'h0, 32'h4, 1'b0);
        cmp(resp_lin_addr, 32'h00ab_cdf3);
        chk({16'h0, 8'h82, 24'hab_cdef, 16'h0010}, RD, 2'h0, 32'h4, 1'b1);
        chk(mk(8'h82, 2'h0), LD, 2'h0, 32'h4, 1'b0);
        cmp(resp_lin_addr, 32'h1234_5004);
        $display("t_desc done");
    endtask
    // every event kind has fired by now, so all three status bits stand
    task automatic t_regs();
        rd(8'h00, 32'h3);
        rd(8'h0c, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h0c, 32'h7);
        rd(8'h08, 32'h7);
        cmp(irq, 1'b1);
        wr(8'h08, 32'h7);
        rd(8'h08, 32'h0);
        cmp(irq, 1'b0);
        wr(8'h0c, 32'h2);
        wr(8'h14, 32'h0);
        chk(mk(8'h72, 2'h0), RD, 2'h0, 32'h0, 1'b1);
        rd(8'h04, 32'h10b);
        rd(8'h14, 32'h1);
        cmp(irq, 1'b0);
        chk(mk(8'hf0, 2'h0), WR, 2'h0, 32'h0, 1'b1);
        // the read-only descriptor was not yet accessed, so the accessed event fires too
        rd(8'h08, 32'h7);
        cmp(irq, 1'b1);
        rd(8'h10, 32'h1234_5000);
        // with checking off a limit overrun passes straight to memory
        wr(8'h00, 32'h2);
        chk(mk(8'hf2, 2'h0), RD, 2'h0, 32'h200, 1'b0);
        wr(8'h00, 32'h3);
        rd(8'h00, 32'h3);
        $display("t_regs done");
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        t_limit();
        t_perm();
        t_desc();
        t_regs();
        finish_test();
    end
endmodule // sdc_checker_test
